// File: rtl/lpmc_pkg.sv
// Constants and carrier types shared by the low-power mode controller.
package lpmc_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	localparam logic [7:0] REG_INT_OPT = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h01;
	localparam logic [7:0] INT_OPT_RESET = 8'h00;
	localparam int INT_OPT_GIE_BIT = 4;

	localparam int ST_STATE_LSB = 0;
	localparam int ST_FREEZE_BIT = 2;
	localparam int ST_OPT_BIT = 3;
	localparam int ST_NMI_PIN_BIT = 4;
	localparam int ST_GIE_BIT = 5;
	localparam int ST_CTX_LSB = 6;

	localparam int EXT_TIMER_BIT = 0;
	localparam int EXT_ADC_BIT = 1;

	localparam int SETTLE_CYCLES = 2048;
	localparam int SETTLE_W = 11;
	localparam logic [SETTLE_W-1:0] SETTLE_LAST = 11'h7FF;

	localparam int VEC_W = 12;
	localparam logic [VEC_W-1:0] VEC_RESET = 12'hFFE;
	localparam logic [VEC_W-1:0] VEC_NMI = 12'hFFC;
	localparam logic [VEC_W-1:0] VEC_PORT_A = 12'hFF6;
	localparam logic [VEC_W-1:0] VEC_PORT_BC = 12'hFF4;
	localparam logic [VEC_W-1:0] VEC_TIMER = 12'hFF2;
	localparam logic [VEC_W-1:0] VEC_ADC = 12'hFF0;

	typedef enum logic [1:0] {CTX_MAIN, CTX_MASK, CTX_NMI} lpmc_ctx_t;

	typedef struct packed {
		logic idle_instr;
		logic deep_instr;
		lpmc_ctx_t ctx;
	} lpmc_core_req_t;

	typedef struct packed {
		logic reset_req;
		logic nmi;
		logic port_a;
		logic port_bc;
		logic timer;
		logic adc;
	} lpmc_wake_t;

	typedef struct packed {
		logic valid;
		logic vec_load;
		logic [VEC_W-1:0] vec_addr;
		logic resume_next;
		lpmc_ctx_t ctx_after;
	} lpmc_restart_t;

endpackage

// File: rtl/lpmc_settle_timer.sv
// Oscillator start-up delay counter used after the deep state.
`timescale 1ns/1ps
module lpmc_settle_timer (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	output logic done_q
);
	import lpmc_pkg::*;

	logic [SETTLE_W-1:0] count_q;
	logic busy_q;

	// Every start restarts the count from zero, even one already running.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0;
			busy_q <= 1'b0;
		end else if (start) begin
			count_q <= '0;
			busy_q <= 1'b1;
		end else if (busy_q) begin
			count_q <= count_q + 11'h001;
			if (count_q == SETTLE_LAST) begin
				busy_q <= 1'b0;
			end
		end
	end

	// The core is released only on terminal count.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
		end else begin
			done_q <= busy_q && !start && (count_q == SETTLE_LAST);
		end
	end

endmodule

// File: rtl/lpmc_top.sv
// Low-power mode controller: idle and deep states, wake and restart.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module lpmc_top (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [lpmc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [lpmc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [lpmc_pkg::DATA_W-1:0] reg_rdata_q,
	input wire lpmc_pkg::lpmc_core_req_t core_req,
	input wire lpmc_pkg::lpmc_wake_t wake_src,
	input wire logic [1:0] periph_on_ext_clk,
	input wire logic watchdog_active,
	input wire logic external_stop_control_option,
	input wire logic nmi_pin,
	output logic core_halt_q,
	output logic osc_run_q,
	output logic wdg_freeze_q,
	output logic lp_ignored_q,
	output lpmc_pkg::lpmc_restart_t restart_q
);
	import lpmc_pkg::*;

	typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_DEEP, ST_SETTLE}
		lpmc_state_t;

	logic rst_sync1_q;
	logic rst_n_q;
	logic nmi_s1_q;
	logic nmi_s2_q;
	logic nmi_s3_q;
	logic nmi_level_q;
	logic opt_q;
	logic opt_taken_q;
	logic gie_q;
	lpmc_state_t state_q;
	lpmc_state_t state_d;
	lpmc_ctx_t ctx_q;
	lpmc_wake_t wake_q;
	lpmc_wake_t idle_wake;
	lpmc_wake_t deep_wake;
	logic pending_irq;
	logic lp_request;
	logic deep_real;
	logic settle_start;
	logic settle_done;
	logic [11:0] settle_cnt_q;

	// Drops requests a state cannot be woken by.
	function automatic lpmc_wake_t qualify(lpmc_wake_t w, logic gie,
			logic deep, logic [1:0] ext);
		lpmc_wake_t q;
		q = w;
		q.nmi = w.nmi & gie;
		q.port_a = w.port_a & gie;
		q.port_bc = w.port_bc & gie;
		q.timer = w.timer & gie & (!deep | ext[EXT_TIMER_BIT]);
		q.adc = w.adc & gie & (!deep | ext[EXT_ADC_BIT]);
		return q;
	endfunction

	function automatic logic any_wake(lpmc_wake_t w);
		return w.reset_req | w.nmi | w.port_a | w.port_bc | w.timer | w.adc;
	endfunction

	// Highest priority first, as in the interrupt vector order.
	function automatic logic [VEC_W-1:0] vector_of(lpmc_wake_t w);
		logic [VEC_W-1:0] v;
		v = VEC_ADC;
		if (w.reset_req) begin
			v = VEC_RESET;
		end else if (w.nmi) begin
			v = VEC_NMI;
		end else if (w.port_a) begin
			v = VEC_PORT_A;
		end else if (w.port_bc) begin
			v = VEC_PORT_BC;
		end else if (w.timer) begin
			v = VEC_TIMER;
		end
		return v;
	endfunction

	function automatic lpmc_restart_t restart_for(lpmc_ctx_t ctx,
			lpmc_wake_t w);
		lpmc_restart_t r;
		r = '0;
		r.valid = 1'b1;
		if (w.reset_req) begin
			r.vec_load = 1'b1;
			r.vec_addr = VEC_RESET;
			r.ctx_after = CTX_MAIN;
		end else if (ctx == CTX_NMI) begin
			r.resume_next = 1'b1;
			r.ctx_after = CTX_NMI;
		end else if (ctx == CTX_MASK && !w.nmi) begin
			r.resume_next = 1'b1;
			r.ctx_after = CTX_MASK;
		end else begin
			r.vec_load = 1'b1;
			r.vec_addr = vector_of(w);
			r.resume_next = 1'b1;
			r.ctx_after = w.nmi ? CTX_NMI : CTX_MASK;
		end
		return r;
	endfunction

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_sync1_q <= 1'b1;
			rst_n_q <= rst_sync1_q;
		end
	end

	// The NMI pin level only counts once two later stages agree.
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			nmi_s1_q <= 1'b0;
			nmi_s2_q <= 1'b0;
			nmi_s3_q <= 1'b0;
			nmi_level_q <= 1'b0;
		end else begin
			nmi_s1_q <= nmi_pin;
			nmi_s2_q <= nmi_s1_q;
			nmi_s3_q <= nmi_s2_q;
			if (nmi_s2_q == nmi_s3_q) begin
				nmi_level_q <= nmi_s3_q;
			end
		end
	end

	// The option bit is a strap, so it is caught once after reset.
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			opt_q <= 1'b0;
			opt_taken_q <= 1'b0;
		end else if (!opt_taken_q) begin
			opt_q <= external_stop_control_option;
			opt_taken_q <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			gie_q <= INT_OPT_RESET[INT_OPT_GIE_BIT];
		end else if (reg_wr && reg_addr == REG_INT_OPT) begin
			gie_q <= reg_wdata[INT_OPT_GIE_BIT];
		end
	end

	// Write-only bits read back as zero; status shows the live state.
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			reg_rdata_q <= '0;
		end else begin
			reg_rdata_q <= '0;
			if (reg_rd && reg_addr == REG_STATUS) begin
				reg_rdata_q[ST_STATE_LSB +: 2] <= state_q;
				reg_rdata_q[ST_FREEZE_BIT] <= wdg_freeze_q;
				reg_rdata_q[ST_OPT_BIT] <= opt_q;
				reg_rdata_q[ST_NMI_PIN_BIT] <= nmi_level_q;
				reg_rdata_q[ST_GIE_BIT] <= gie_q;
				reg_rdata_q[ST_CTX_LSB +: 2] <= ctx_q;
			end
		end
	end

	always_comb begin
		pending_irq = wake_src.nmi | (gie_q & (wake_src.port_a |
			wake_src.port_bc | wake_src.timer | wake_src.adc));
		lp_request = core_req.idle_instr | core_req.deep_instr;
		deep_real = !watchdog_active | (opt_q & nmi_level_q);
		idle_wake = qualify(wake_src, gie_q, 1'b0, periph_on_ext_clk);
		deep_wake = qualify(wake_src, gie_q, 1'b1, periph_on_ext_clk);
		settle_start = (state_q == ST_DEEP) && any_wake(deep_wake);
	end

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_RUN: begin
				if (lp_request && !pending_irq) begin
					if (core_req.idle_instr || !deep_real) begin
						state_d = ST_IDLE;
					end else begin
						state_d = ST_DEEP;
					end
				end
			end
			ST_IDLE: begin
				if (any_wake(idle_wake)) begin
					state_d = ST_RUN;
				end
			end
			ST_DEEP: begin
				if (settle_start) begin
					state_d = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (settle_done) begin
					state_d = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// The context is held for the whole stay so the restart can use it.
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctx_q <= CTX_MAIN;
		end else if (state_q == ST_RUN && state_d != ST_RUN) begin
			ctx_q <= core_req.ctx;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wake_q <= '0;
		end else if (settle_start) begin
			wake_q <= deep_wake;
		end
	end

	lpmc_settle_timer u_settle (
		.clk(core_clk),
		.rst_n(rst_n_q),
		.start(settle_start),
		.done_q(settle_done)
	);

	// Peripherals keep their clock in idle; only the deep state stops it.
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			core_halt_q <= 1'b0;
			osc_run_q <= 1'b1;
			wdg_freeze_q <= 1'b0;
		end else begin
			core_halt_q <= state_d != ST_RUN;
			osc_run_q <= state_d != ST_DEEP;
			wdg_freeze_q <= watchdog_active &&
				(state_d == ST_DEEP || state_d == ST_SETTLE);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			lp_ignored_q <= 1'b0;
		end else begin
			lp_ignored_q <= (state_q == ST_RUN) && lp_request &&
				pending_irq;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			restart_q <= '0;
		end else if (state_q == ST_IDLE && any_wake(idle_wake)) begin
			restart_q <= restart_for(ctx_q, idle_wake);
		end else if (state_q == ST_SETTLE && settle_done) begin
			restart_q <= restart_for(ctx_q, wake_q);
		end else begin
			restart_q <= '0;
		end
	end

	// Counts cycles spent settling so the delay can be checked.
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			settle_cnt_q <= '0;
		end else if (state_q == ST_SETTLE) begin
			settle_cnt_q <= settle_cnt_q + 12'h001;
		end else begin
			settle_cnt_q <= '0;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n_q);

	AST_IDLE_ENTRY: assert property (
		state_q == ST_RUN && core_req.idle_instr && !pending_irq
		|=> state_q == ST_IDLE && core_halt_q)
		else $error("Idle instruction did not enter idle.");

	AST_HALT_HELD: assert property (
		state_q != ST_RUN && $past(state_q) != ST_RUN |-> core_halt_q)
		else $error("Core not halted in a low-power state.");

	AST_IDLE_OSC: assert property (
		state_q == ST_IDLE |-> osc_run_q)
		else $error("Oscillator stopped during idle.");

	AST_IDLE_STAY: assert property (
		state_q == ST_IDLE && !any_wake(idle_wake) |=> state_q == ST_IDLE)
		else $error("Idle left without a wake event.");

	AST_RESET_VECTOR: assert property (
		state_q == ST_IDLE && wake_src.reset_req
		|=> restart_q.valid && restart_q.vec_addr == VEC_RESET)
		else $error("Reset wake did not load the reset vector.");

	AST_DEEP_OSC: assert property (
		state_q == ST_DEEP |-> !osc_run_q && core_halt_q)
		else $error("Oscillator running in deep state.");

	AST_DEEP_STAY: assert property (
		state_q == ST_DEEP && !any_wake(deep_wake) |=> state_q == ST_DEEP)
		else $error("Deep state left without a wake event.");

	AST_SETTLE_LEN: assert property (
		state_q == ST_SETTLE && settle_done
		|-> settle_cnt_q == 12'(SETTLE_CYCLES) ##1 restart_q.valid)
		else $error("Settle delay is not 2048 cycles.");

	AST_WDG_SUBST: assert property (
		state_q == ST_RUN && core_req.deep_instr && !pending_irq &&
		watchdog_active && !(opt_q && nmi_level_q) |=> state_q == ST_IDLE)
		else $error("Deep instruction not replaced by idle.");

	AST_WDG_FREEZE: assert property (
		state_q == ST_DEEP |-> wdg_freeze_q == $past(watchdog_active))
		else $error("Watchdog freeze wrong in deep state.");

	AST_NMI_NOWAKE: assert property (
		state_q == ST_IDLE && !gie_q && !wake_src.reset_req
		|=> state_q == ST_IDLE)
		else $error("Idle woken with global enable clear.");

	AST_NMI_CTX: assert property (
		restart_q.valid && ctx_q == CTX_NMI && restart_q.vec_addr != VEC_RESET
		|-> restart_q.resume_next && restart_q.ctx_after == CTX_NMI)
		else $error("Wake from NMI context left NMI context.");

	AST_REFUSE: assert property (
		state_q == ST_RUN && lp_request && pending_irq
		|=> state_q == ST_RUN && lp_ignored_q && !core_halt_q)
		else $error("Low-power instruction taken with request pending.");

	COV_IDLE_WAKE: cover property (
		state_q == ST_IDLE ##1 state_q == ST_RUN ##0 restart_q.valid);

	COV_DEEP_ENTRY: cover property (
		state_q == ST_RUN && watchdog_active ##1 state_q == ST_DEEP);

	COV_SETTLE_DONE: cover property (
		state_q == ST_SETTLE && settle_done);

	COV_MASK_NMI: cover property (
		restart_q.valid && ctx_q == CTX_MASK &&
		restart_q.vec_addr == VEC_NMI);

endmodule

// File: testbench/lpmc_core_model.sv
// Core and interrupt sources facing the low-power controller.
`timescale 1ns/1ps
module lpmc_core_model (
	input wire logic clk,
	input wire lpmc_pkg::lpmc_restart_t restart,
	output lpmc_pkg::lpmc_core_req_t core_req,
	output lpmc_pkg::lpmc_wake_t wake_src
);
	import lpmc_pkg::*;
	lpmc_wake_t add_req;
	logic drop_req;
	initial begin
		core_req = '0;
		wake_src = '0;
		add_req = '0;
		drop_req = 1'b0;
	end
	// Only the main oscillator is modelled, so nothing must start first.
	task automatic issue(input logic deep, input lpmc_ctx_t ctx);
		@(posedge clk);
		core_req <= '{idle_instr: !deep, deep_instr: deep, ctx: ctx};
		@(posedge clk);
		core_req <= '0;
	endtask
	// Tasks only post requests; one process drives the sources, so a new
	// request and the clearing of a serviced one never race on one edge.
	task automatic raise(input lpmc_wake_t w);
		#1;
		add_req = w;
		@(posedge clk);
		#1;
		add_req = '0;
	endtask
	task automatic drop();
		#1;
		drop_req = 1'b1;
		@(posedge clk);
		#1;
		drop_req = 1'b0;
	endtask
	// A request is held until the next restart or a drop; a restart clears every held request.
	always @(posedge clk) begin
		if (drop_req) begin
			wake_src <= '0;
		end else if (restart.valid) begin
			wake_src <= add_req;
		end else begin
			wake_src <= wake_src | add_req;
		end
	end
endmodule

// File: testbench/lpmc_top_bench.sv
// Self-checking bench for the low-power mode controller.
`timescale 1ns/1ps
module lpmc_top_bench;
	import lpmc_pkg::*;
	logic core_clk;
	logic resetn;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [DATA_W-1:0] reg_rdata_q;
	lpmc_core_req_t core_req;
	lpmc_wake_t wake_src;
	logic [1:0] periph_on_ext_clk;
	logic watchdog_active;
	logic external_stop_control_option;
	logic nmi_pin;
	logic core_halt_q;
	logic osc_run_q;
	logic wdg_freeze_q;
	logic lp_ignored_q;
	lpmc_restart_t restart_q;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	int n;
	logic [7:0] rd_v;

	lpmc_top dut_u (
		.core_clk(core_clk),
		.resetn(resetn),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata_q(reg_rdata_q),
		.core_req(core_req),
		.wake_src(wake_src),
		.periph_on_ext_clk(periph_on_ext_clk),
		.watchdog_active(watchdog_active),
		.external_stop_control_option(external_stop_control_option),
		.nmi_pin(nmi_pin),
		.core_halt_q(core_halt_q),
		.osc_run_q(osc_run_q),
		.wdg_freeze_q(wdg_freeze_q),
		.lp_ignored_q(lp_ignored_q),
		.restart_q(restart_q)
	);
	lpmc_core_model model_u (.clk(core_clk), .restart(restart_q),
		.core_req(core_req), .wake_src(wake_src));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic finish_test();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// The whole run needs about 4200 cycles; this ceiling leaves ample room.
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata_q;
	endtask

	// A hang here is cut short by the cycle ceiling.
	task automatic wait_rs(output int c);
		c = 0;
		do begin
			@(posedge core_clk);
			#1;
			c++;
		end while (restart_q.valid !== 1'b1);
	endtask

	task automatic exp_rs(input logic vl, input logic [11:0] va,
		input lpmc_ctx_t cx);
		chk("vec_load", vl, restart_q.vec_load);
		if (vl) begin
			chk("vec_addr", va, restart_q.vec_addr);
		end
		chk("resume_next", 1'b1, restart_q.resume_next);
		chk("ctx_after", cx, restart_q.ctx_after);
	endtask

	initial begin
		resetn = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		periph_on_ext_clk = 2'h0;
		watchdog_active = 1'b0;
		external_stop_control_option = 1'b0;
		nmi_pin = 1'b0;
		repeat (8) @(posedge core_clk);
		chk("halt_rst", 1'b0, core_halt_q);
		chk("osc_rst", 1'b1, osc_run_q);
		resetn <= 1'b1;
		repeat (6) @(posedge core_clk);
		rd(REG_STATUS, rd_v);
		chk("gie_rst", 1'b0, rd_v[ST_GIE_BIT]);
		wr(REG_INT_OPT, 8'h10);
		rd(REG_INT_OPT, rd_v);
		chk("int_opt_read", 8'h00, rd_v);
		rd(8'h7F, rd_v);
		chk("unmapped", 8'h00, rd_v);
		rd(REG_STATUS, rd_v);
		chk("gie_set", 1'b1, rd_v[ST_GIE_BIT]);
		model_u.issue(1'b0, CTX_MAIN);
		#1;
		chk("idle_halt", 1'b1, core_halt_q);
		rd(REG_STATUS, rd_v);
		chk("idle_state", 2'h1, rd_v[1:0]);
		chk("idle_osc", 1'b1, osc_run_q);
		model_u.raise(6'h08);
		wait_rs(n);
		chk("idle_wake", 1'b1, n <= 2);
		exp_rs(1'b1, VEC_PORT_A, CTX_MASK);
		model_u.raise(6'h02);
		model_u.issue(1'b0, CTX_MAIN);
		#1;
		chk("lp_ignored", 1'b1, lp_ignored_q);
		chk("no_halt", 1'b0, core_halt_q);
		model_u.drop();
		model_u.issue(1'b0, CTX_NMI);
		model_u.raise(6'h04);
		wait_rs(n);
		exp_rs(1'b0, 12'h000, CTX_NMI);
		model_u.issue(1'b0, CTX_MASK);
		model_u.raise(6'h01);
		wait_rs(n);
		exp_rs(1'b0, 12'h000, CTX_MASK);
		@(posedge core_clk);
		watchdog_active <= 1'b1;
		model_u.issue(1'b1, CTX_MASK);
		#1;
		chk("wdg_idle_osc", 1'b1, osc_run_q);
		chk("wdg_idle_halt", 1'b1, core_halt_q);
		model_u.raise(6'h10);
		wait_rs(n);
		chk("wdg_idle_wake", 1'b1, n <= 2);
		exp_rs(1'b1, VEC_NMI, CTX_NMI);
		@(posedge core_clk);
		watchdog_active <= 1'b0;
		model_u.issue(1'b1, CTX_MAIN);
		#1;
		chk("deep_osc", 1'b0, osc_run_q);
		model_u.raise(6'h03);
		repeat (20) @(posedge core_clk);
		#1;
		chk("deep_blocked", 1'b1, core_halt_q & ~osc_run_q);
		@(posedge core_clk);
		periph_on_ext_clk <= 2'h2;
		wait_rs(n);
		chk("settle", 1'b1, n >= SETTLE_CYCLES &&
			n <= SETTLE_CYCLES + 2);
		// Only the converter runs from an external clock, so the timer
		// request must not win the vector.
		exp_rs(1'b1, VEC_ADC, CTX_MASK);
		wr(REG_INT_OPT, 8'h00);
		model_u.issue(1'b0, CTX_MAIN);
		model_u.raise(6'h10);
		repeat (20) @(posedge core_clk);
		#1;
		chk("nmi_gie_off", 1'b1, core_halt_q);
		model_u.raise(6'h20);
		wait_rs(n);
		chk("rst_vec", VEC_RESET, restart_q.vec_addr);
		// A fresh reset is needed because the option strap is caught once.
		@(posedge core_clk);
		resetn <= 1'b0;
		watchdog_active <= 1'b1;
		external_stop_control_option <= 1'b1;
		nmi_pin <= 1'b1;
		repeat (8) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (8) @(posedge core_clk);
		model_u.issue(1'b1, CTX_MAIN);
		#1;
		chk("stop_osc", 1'b0, osc_run_q);
		chk("wdg_frozen", 1'b1, wdg_freeze_q);
		model_u.raise(6'h20);
		wait_rs(n);
		chk("rst_ctx", CTX_MAIN, restart_q.ctx_after);
		// With the pin low again the option alone must not allow deep.
		@(posedge core_clk);
		nmi_pin <= 1'b0;
		repeat (6) @(posedge core_clk);
		model_u.issue(1'b1, CTX_MAIN);
		#1;
		chk("nmi_low_osc", 1'b1, osc_run_q);
		chk("nmi_low_frz", 1'b0, wdg_freeze_q);
		model_u.raise(6'h20);
		wait_rs(n);
		chk("nmi_low_wake", 1'b1, n <= 2);
		chk("nmi_low_vec", VEC_RESET, restart_q.vec_addr);
		finish_test();
	end
endmodule
